// >>> hw/reset_config_byte_fetch.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcf_params.svh"
module reset_config_byte_fetch (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        externalAccessSelectN,
	input  wire logic [7:0]  onchipCfgLow,
	input  wire logic [7:0]  onchipCfgHigh,
	output logic             memReq,
	output logic [23:0]      memAddr,
	output logic             memPageMode,
	input  wire logic        memAck,
	input  wire logic [7:0]  memData,
	input  wire logic        port2Bit1,
	output logic             coreRelease,
	output logic             pageModeN,
	output logic             sourceMode,
	output logic             aleExtendN,
	output logic [1:0]       strobeRangeSel,
	output logic [1:0]       waitStatesA,
	output logic [1:0]       waitStatesB,
	output logic             waitRegion01N,
	output logic [2:0]       interruptFrameBytes,
	output logic             codeUpperMapEn,
	output logic             topArrayReserved
);
	// ------------------------------------------------------------
	// Fetch sequencer
	// ------------------------------------------------------------
	rcf_pkg::rcf_state_e stateFf;
	rcf_pkg::rcf_state_e nxtState;
	logic [7:0]          cfgLowFf;
	logic [7:0]          cfgHighFf;
	logic                pageSeenFf;
	logic                extSelFf;
	logic                extStep;
	logic                loadOnchip;
	logic                loadLow;
	logic                loadHigh;
	logic [7:0]          nxtCfgLow;
	logic [7:0]          nxtCfgHigh;
	logic [1:0]          waitSelN [`RCF_WAIT_REGIONS];
	logic [1:0]          waitNext [`RCF_WAIT_REGIONS];
	logic [1:0]          waitAFf;
	logic [1:0]          waitBFf;
	logic [2:0]          frameBytesFf;
	logic                mapEnFf;

	function automatic logic [1:0] selPair(
		input logic [7:0] cfgByte,
		input int         hiPos,
		input int         loPos
	);
		selPair = {cfgByte[hiPos], cfgByte[loPos]};
	endfunction : selPair

	// The pin is sampled once after reset; a mid-fetch change would mix sources.
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			extSelFf <= 1'b0;
		else if (stateFf == rcf_pkg::ST_START)
			extSelFf <= ~externalAccessSelectN;
	end

	assign extStep = memAck;

	always_comb
	begin
		nxtState = stateFf;
		unique case (stateFf)
			rcf_pkg::ST_START:
				nxtState = externalAccessSelectN ? rcf_pkg::ST_DONE : rcf_pkg::ST_LOW_FIRST;
			rcf_pkg::ST_LOW_FIRST:
				if (extStep)
					nxtState = rcf_pkg::ST_LOW_SECOND;
			rcf_pkg::ST_LOW_SECOND:
				if (extStep)
					nxtState = rcf_pkg::ST_HIGH;
			rcf_pkg::ST_HIGH:
				if (extStep)
					nxtState = rcf_pkg::ST_DONE;
			rcf_pkg::ST_DONE:
				nxtState = rcf_pkg::ST_DONE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			stateFf <= rcf_pkg::ST_START;
		else
			stateFf <= nxtState;
	end

	// ------------------------------------------------------------
	// External bus request
	// ------------------------------------------------------------
	always_comb
	begin
		memReq  = 1'b0;
		memAddr = `RCF_ADDR_LOW;
		unique case (stateFf)
			rcf_pkg::ST_LOW_FIRST,
			rcf_pkg::ST_LOW_SECOND:
			begin
				memReq  = 1'b1;
				memAddr = `RCF_ADDR_LOW;
			end
			rcf_pkg::ST_HIGH:
			begin
				memReq  = 1'b1;
				memAddr = `RCF_ADDR_HIGH;
			end
			default:
			begin
				memReq  = 1'b0;
				memAddr = `RCF_ADDR_LOW;
			end
		endcase
	end

	assign memPageMode = pageSeenFf;

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			pageSeenFf <= 1'b0;
		else if (stateFf == rcf_pkg::ST_LOW_FIRST && memAck)
			pageSeenFf <= ~port2Bit1;
	end

	// ------------------------------------------------------------
	// Load selection
	// ------------------------------------------------------------
	// Reset feeds the erased-byte value through the load path, so raw and decoded
	// settings always start from one and the same byte.
	always_comb
	begin
		loadOnchip = (stateFf == rcf_pkg::ST_START) && externalAccessSelectN;
		loadLow    = loadOnchip || ((stateFf == rcf_pkg::ST_LOW_SECOND) && memAck);
		loadHigh   = loadOnchip || ((stateFf == rcf_pkg::ST_HIGH) && memAck);
	end

	always_comb
	begin
		if (reset)
			nxtCfgLow = `RCF_CFG_RESET;
		else if (loadOnchip)
			nxtCfgLow = onchipCfgLow;
		else
			nxtCfgLow = memData;
	end

	always_comb
	begin
		if (reset)
			nxtCfgHigh = `RCF_CFG_RESET;
		else if (loadOnchip)
			nxtCfgHigh = onchipCfgHigh;
		else
			nxtCfgHigh = memData;
	end

	// ------------------------------------------------------------
	// Configuration latches
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (reset || loadLow)
			cfgLowFf <= nxtCfgLow;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset || loadHigh)
			cfgHighFf <= nxtCfgHigh;
	end

	// ------------------------------------------------------------
	// Wait-state decode
	// ------------------------------------------------------------
	// Decoding the byte on its way in lets the counts settle at the same edge
	// as the raw latch, so no setting lags the core release.
	assign waitSelN[`RCF_REGION_A] = selPair(nxtCfgLow, `RCF_B0_WSA_HI, `RCF_B0_WSA_LO);
	assign waitSelN[`RCF_REGION_B] = selPair(nxtCfgHigh, `RCF_B1_WSB_HI, `RCF_B1_WSB_LO);

	genvar region;
	generate
		for (region = `RCF_REGION_A; region < `RCF_WAIT_REGIONS; region = region + 1)
		begin : gWaitDecode
			rcf_wait_decode uWait (
				.selN       (waitSelN[region]),
				.waitStates (waitNext[region])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Decoded settings
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (reset || loadLow)
			waitAFf <= waitNext[`RCF_REGION_A];
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset || loadHigh)
			waitBFf <= waitNext[`RCF_REGION_B];
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset || loadHigh)
			frameBytesFf <= nxtCfgHigh[`RCF_B1_INTERRUPT_FRAME_WIDTH] ? `RCF_FRAME_LONG : `RCF_FRAME_SHORT;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset || loadHigh)
			mapEnFf <= ~nxtCfgHigh[`RCF_B1_CODE_UPPER_MAP_N];
	end

	// ------------------------------------------------------------
	// Setting outputs
	// ------------------------------------------------------------
	assign coreRelease         = (stateFf == rcf_pkg::ST_DONE);
	assign pageModeN           = cfgLowFf[`RCF_B0_PAGE];
	assign sourceMode          = cfgLowFf[`RCF_B0_SRC];
	assign aleExtendN          = cfgLowFf[`RCF_B0_XALE];
	assign strobeRangeSel      = selPair(cfgLowFf, `RCF_B0_RD1, `RCF_B0_RD0);
	assign waitStatesA         = waitAFf;
	assign waitStatesB         = waitBFf;
	assign waitRegion01N       = cfgHighFf[`RCF_B1_WSB];
	assign interruptFrameBytes = frameBytesFf;
	assign codeUpperMapEn      = mapEnFf;
	assign topArrayReserved    = extSelFf;
endmodule : reset_config_byte_fetch
`default_nettype wire

// >>> hw/rcf_params.svh
// What this block does
// - At reset the block loads the memory interface, opcode mode, stack frame and code map settings.
// - Only the low byte at FF:FFF8h and the high byte at FF:FFF9h are used; other array bytes are ignored.
// - With external configuration the top eight addresses hold an eight-byte array that the memory must supply.
// - With the select input low both bytes are fetched over the external bus.
// - With the select input high the bytes come from on-chip memory and no external fetch is made.
// - With on-chip configuration the top eight external addresses stay ordinary memory.
// - Parts with masked on-chip program memory keep their configuration on chip.
// - The low byte is fetched twice and port 2 bit 1 low during the first fetch selects page mode.
// - The frame setting makes interrupts push two or four bytes and the return pops the same count.
// - A cleared code map bit maps the upper 16 Kbytes of on-chip code into region 00.
`ifndef RCF_PARAMS_SVH
`define RCF_PARAMS_SVH
`define RCF_ADDR_LOW      24'hFFFFF8
`define RCF_ADDR_HIGH     24'hFFFFF9
`define RCF_CFG_RESET     8'hFF
`define RCF_B0_WSA_HI     6
`define RCF_B0_WSA_LO     5
`define RCF_B0_XALE       4
`define RCF_B0_RD1        3
`define RCF_B0_RD0        2
`define RCF_B0_PAGE       1
`define RCF_B0_SRC        0
`define RCF_B1_INTERRUPT_FRAME_WIDTH       4
`define RCF_B1_WSB        3
`define RCF_B1_WSB_HI     2
`define RCF_B1_WSB_LO     1
`define RCF_B1_CODE_UPPER_MAP_N       0
`define RCF_FRAME_SHORT   3'h2
`define RCF_FRAME_LONG    3'h4
`define RCF_WAIT_REGION01 2'h1
`define RCF_REGION_A      0
`define RCF_REGION_B      1
`define RCF_WAIT_REGIONS  2
`endif

// >>> hw/rcf_pkg.sv
package rcf_pkg;
	typedef enum logic [2:0] {
		ST_START,
		ST_LOW_FIRST,
		ST_LOW_SECOND,
		ST_HIGH,
		ST_DONE
	} rcf_state_e;
	typedef logic [1:0] rcf_wait_t;
endpackage : rcf_pkg

// >>> hw/rcf_wait_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcf_params.svh"
module rcf_wait_decode (
	input  wire logic [1:0] selN,
	output logic      [1:0] waitStates
);
	// Active-low pattern: inverting gives the count directly.
	assign waitStates = ~selN;
endmodule : rcf_wait_decode
`default_nettype wire

// >>> tb/rcf_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcf_mem_model (
	input  wire logic        ref_clk,
	input  wire logic        memReq,
	input  wire logic [23:0] memAddr,
	input  wire logic [1:0]  lat,
	input  wire logic [7:0]  extLo,
	input  wire logic [7:0]  extHi,
	output logic             memAck,
	output logic [7:0]       memData
);
	logic [1:0] cnt_ff;
	logic [7:0] val;
	// The top eight addresses hold the array; unused bytes read as FF.
	assign val = memAddr[2:0] == 3'h0 ? extLo : memAddr[2:0] == 3'h1 ? extHi : 8'hFF;
	assign memAck = memReq && cnt_ff == lat;
	// Off the ack the bus shows the inverse, so stale data cannot pass for a fetch.
	assign memData = memAck ? val : ~val;
	always_ff @(posedge ref_clk)
		cnt_ff <= (memReq && !memAck) ? cnt_ff + 2'h1 : 2'h0;
endmodule : rcf_mem_model
`default_nettype wire

// >>> tb/rcf_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rcf_checker (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        externalAccessSelectN,
	input wire logic [7:0]  onchipCfgLow,
	input wire logic [7:0]  onchipCfgHigh,
	input wire logic        memReq,
	input wire logic [23:0] memAddr,
	input wire logic        coreRelease,
	input wire logic [1:0]  waitStatesA,
	input wire logic [2:0]  interruptFrameBytes,
	input wire logic        codeUpperMapEn,
	input wire logic        topArrayReserved
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence relDone;
		coreRelease && !memReq;
	endsequence
	a_ext_start: assert property (
		$fell(reset) && !externalAccessSelectN |=> memReq && memAddr == 24'hFFFFF8) else $error("no low fetch");
	a_onchip_quiet: assert property (
		$fell(reset) && externalAccessSelectN |=> relDone) else $error("on-chip load not quiet");
	a_addr_top: assert property (
		memReq |-> memAddr == 24'hFFFFF8 || memAddr == 24'hFFFFF9) else $error("bad fetch address");
	a_done_hold: assert property (
		coreRelease |=> relDone and ($stable(interruptFrameBytes) && $stable(codeUpperMapEn)))
		else $error("not held");
	a_ext_timely: assert property (
		$rose(memReq) |-> ##[1:40] coreRelease) else $error("load too slow");
	a_frame_onchip: assert property (
		(relDone and !topArrayReserved) |-> interruptFrameBytes == (onchipCfgHigh[4] ? 3'h4 : 3'h2))
		else $error("frame");
	a_map_onchip: assert property (
		(relDone and !topArrayReserved) |-> codeUpperMapEn == !onchipCfgHigh[0]) else $error("code map");
	a_wait_onchip: assert property (
		(relDone and !topArrayReserved) |-> waitStatesA == ~onchipCfgLow[6:5]) else $error("wait decode");
endmodule : rcf_checker
`default_nettype wire

// >>> tb/test_reset_config_byte_fetch.sv
`timescale 1ns/1ps
`default_nettype none
module test_reset_config_byte_fetch;
	logic ref_clk = 1'b0, reset = 1'b1, externalAccessSelectN = 1'b0, port2Bit1 = 1'b0, memAck;
	logic [7:0] onchipCfgLow = 8'hFF, onchipCfgHigh = 8'hFF, extLo = 8'hFF, extHi = 8'hFF, memData;
	logic [1:0] lat = 2'h0, strobeRangeSel, waitStatesA, waitStatesB;
	logic [23:0] memAddr;
	logic [2:0] interruptFrameBytes;
	logic memReq, memPageMode, coreRelease, pageModeN, sourceMode, aleExtendN, waitRegion01N;
	logic codeUpperMapEn, topArrayReserved;
	int errTotal = 0, compares = 0, cyc = 0, acks = 0;
	reset_config_byte_fetch i_reset_config_byte_fetch (.*);
	rcf_mem_model i_rcf_mem_model (.*);
	initial forever #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cyc++;
		if (reset) acks = 0;
		else if (memReq && memAck) acks++;
		if (cyc > 5000)
		begin
			errTotal++;
			test_done();
		end
	end
	task chk(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errTotal++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// The select pin is flipped after the start edge, which the loader must ignore.
	task boot(input logic sel);
		reset = 1'b1;
		externalAccessSelectN = sel;
		repeat (12) @(posedge ref_clk);
		#1 reset = 1'b0;
		@(posedge ref_clk);
		#1 externalAccessSelectN = !sel;
		repeat (40) if (!coreRelease) @(posedge ref_clk);
		#1;
	endtask : boot
	task check_cfg(input logic [7:0] lo, input logic [7:0] hi);
		chk(24'(pageModeN), 24'(lo[1]));
		chk(24'(sourceMode), 24'(lo[0]));
		chk(24'(aleExtendN), 24'(lo[4]));
		chk(24'(strobeRangeSel), 24'(lo[3:2]));
		chk(24'(waitStatesA), 24'(lo[6:5] ^ 2'h3));
		chk(24'(waitStatesB), 24'(hi[2:1] ^ 2'h3));
		chk(24'(waitRegion01N), 24'(hi[3]));
		chk(24'(interruptFrameBytes), 24'(hi[4] ? 3'h4 : 3'h2));
		chk(24'(codeUpperMapEn), 24'(!hi[0]));
		chk(24'(coreRelease), 24'h1);
	endtask : check_cfg
	task ext_fetch(input logic [7:0] lo, input logic [7:0] hi, input logic p2, input logic [1:0] l);
		extLo = lo;
		extHi = hi;
		port2Bit1 = p2;
		lat = l;
		boot(1'b0);
		chk(acks[23:0], 24'h3);
		chk(24'(memPageMode), 24'(!p2));
		chk(24'(topArrayReserved), 24'h1);
		check_cfg(lo, hi);
	endtask : ext_fetch
	task onchip_fetch(input logic [7:0] lo, input logic [7:0] hi);
		onchipCfgLow = lo;
		onchipCfgHigh = hi;
		extLo = ~lo;
		extHi = ~hi;
		boot(1'b1);
		chk(acks[23:0], 24'h0);
		chk(24'(topArrayReserved), 24'h0);
		check_cfg(lo, hi);
	endtask : onchip_fetch
	task test_done;
		$display("errors %0d compares %0d", errTotal, compares);
		if (errTotal == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	initial
	begin
		for (int i = 0; i < 4; i++)
		begin
			ext_fetch({1'b1, i[1:0], 5'h0A}, {3'h7, i[0], 1'b1, i[1:0], ~i[0]}, i[0], i[1:0]);
			onchip_fetch({1'b1, ~i[1:0], 5'h15}, {3'h7, ~i[0], 1'b0, ~i[1:0], i[0]});
		end
		test_done();
	end
endmodule : test_reset_config_byte_fetch
bind reset_config_byte_fetch rcf_checker i_rcf_checker (.*);
`default_nettype wire
